// File: verilog/rtou_cfg.svh
// Register offsets, field positions and reset values of the real-time output unit.
`ifndef RTOU_CFG_SVH
`define RTOU_CFG_SVH

`define RTOU_ADDR_W       28
`define RTOU_OFS_BUF_LO   28'hffff6e0
`define RTOU_OFS_BUF_HI   28'hffff6e1
`define RTOU_OFS_SELECT   28'hffff6e4
`define RTOU_OFS_CONTROL  28'hffff6e5

`define RTOU_CTL_EN_BIT   7
`define RTOU_CTL_EDGE_BIT 6
`define RTOU_CTL_WIDE_BIT 5
`define RTOU_CTL_SRC_BIT  4

`define RTOU_RST_CONTROL  8'h00
`define RTOU_RST_SELECT   8'h00
`define RTOU_RST_BUFFER   4'h0

`endif

// File: verilog/rtou_pkg.sv
// Types shared by the real-time output unit.
package rtou_pkg;

   typedef struct packed {
      logic en;
      logic edge_rise;
      logic wide;
      logic src;
   } rtou_ctrl_s;

   typedef struct packed {
      logic rise;
      logic fall;
   } rtou_edges_s;

endpackage

// File: verilog/rtou_edge.sv
// Edge detector for one trigger input on the system clock.
`timescale 1ns/10ps

module rtou_edge (
   input  wire logic                 clk,
   input  wire logic                 reset,
   input  wire logic                 sig,
   output rtou_pkg::rtou_edges_s     edges
);

   logic prev_reg;

   always_ff @(posedge clk) begin
      if (reset) begin
         prev_reg <= 1'b0;
      end else begin
         prev_reg <= sig;
      end
   end

   assign edges.rise = sig & ~prev_reg;
   assign edges.fall = ~sig & prev_reg;

endmodule

// File: verilog/rtou_top.sv
// Six-bit real-time output port with trigger-loaded output latches.
`timescale 1ns/10ps
`include "rtou_cfg.svh"

module rtou_top (
   input  wire logic                    clk,
   input  wire logic                    reset,
   input  wire logic [`RTOU_ADDR_W-1:0] addr,
   input  wire logic [7:0]              wdata,
   input  wire logic                    wr,
   input  wire logic                    rd,
   output logic      [7:0]              rdata,
   input  wire logic                    first_timer_match_pulse,
   input  wire logic                    second_timer_interrupt,
   input  wire logic                    third_timer_interrupt,
   output logic      [5:0]              realtime_output_signals
);

   ////////////////////////////////////////////////////////////////////
   // Registers.

   rtou_pkg::rtou_ctrl_s ctrl_reg;
   rtou_pkg::rtou_ctrl_s ctrl_next;
   logic [7:0]           select_reg;
   logic [7:0]           select_next;
   logic [3:0]           buf_lo_reg;
   logic [3:0]           buf_lo_next;
   logic [3:0]           buf_hi_reg;
   logic [3:0]           buf_hi_next;
   logic [3:0]           lat_lo_reg;
   logic [3:0]           lat_lo_next;
   logic [1:0]           lat_hi_reg;
   logic [1:0]           lat_hi_next;
   logic [5:0]           out_next;
   logic [7:0]           rdata_next;

   // Only the upper nibble of the control reset value is stored.
   wire [7:0]            ctrl_rst = `RTOU_RST_CONTROL;

   ////////////////////////////////////////////////////////////////////
   // Address decode.

   wire hit_lo   = (addr == `RTOU_OFS_BUF_LO);
   wire hit_hi   = (addr == `RTOU_OFS_BUF_HI);
   wire hit_sel  = (addr == `RTOU_OFS_SELECT);
   wire hit_ctl  = (addr == `RTOU_OFS_CONTROL);
   wire wr_lo    = wr & hit_lo;
   wire wr_hi    = wr & hit_hi;
   wire wr_buf   = wr_lo | wr_hi;

   // Combined layout lets either address load the whole byte.
   wire ld_lo    = wr_lo | (wr_hi & ctrl_reg.wide);
   wire ld_hi    = wr_hi | (wr_lo & ctrl_reg.wide);

   wire [7:0] ctrl_rd = {ctrl_reg, 4'h0};
   wire [7:0] buf_rd  = {buf_hi_reg, buf_lo_reg};

   ////////////////////////////////////////////////////////////////////
   // Trigger edges and selection.

   rtou_pkg::rtou_edges_s e1;
   rtou_pkg::rtou_edges_s e2;
   rtou_pkg::rtou_edges_s e3;

   rtou_edge u_edge1 (
      .clk   (clk),
      .reset (reset),
      .sig   (first_timer_match_pulse),
      .edges (e1)
   );

   rtou_edge u_edge2 (
      .clk   (clk),
      .reset (reset),
      .sig   (second_timer_interrupt),
      .edges (e2)
   );

   rtou_edge u_edge3 (
      .clk   (clk),
      .reset (reset),
      .sig   (third_timer_interrupt),
      .edges (e3)
   );

   // The timers share the system clock, so no synchroniser is needed.
   wire t1_sel = ctrl_reg.edge_rise ? e1.rise : e1.fall;
   wire t2     = e2.rise;
   wire t3     = e3.rise;

   // Each nibble listens to one source only; an edge on an unselected
   // timer in the same cycle is ignored.
   wire trig_split_hi = ctrl_reg.src ? t2 : t3;
   wire trig_split_lo = ctrl_reg.src ? t1_sel : t2;
   wire trig_comb     = ctrl_reg.src ? t1_sel : t2;
   wire trig_hi = ctrl_reg.wide ? trig_comb : trig_split_hi;
   wire trig_lo = ctrl_reg.wide ? trig_comb : trig_split_lo;

   ////////////////////////////////////////////////////////////////////
   // Next-state logic.

   always_comb begin
      ctrl_next   = ctrl_reg;
      select_next = select_reg;
      buf_lo_next = buf_lo_reg;
      buf_hi_next = buf_hi_reg;
      lat_lo_next = lat_lo_reg;
      lat_hi_next = lat_hi_reg;
      if (wr & hit_ctl) begin
         ctrl_next = wdata[`RTOU_CTL_EN_BIT:`RTOU_CTL_SRC_BIT];
      end
      if (wr & hit_sel) begin
         select_next = wdata;
      end
      if (ld_lo) begin
         buf_lo_next = wdata[3:0];
      end
      if (ld_hi) begin
         buf_hi_next = wdata[7:4];
      end
      if (ctrl_reg.en) begin
         // Writes and triggers must not coincide; the trigger uses the
         // value held before this cycle's write.
         if (trig_lo) begin
            lat_lo_next = buf_lo_reg;
         end
         if (trig_hi) begin
            lat_hi_next = buf_hi_reg[1:0];
         end
      end else begin
         if (ld_lo) begin
            lat_lo_next = wdata[3:0];
         end
         if (ld_hi) begin
            lat_hi_next = wdata[5:4];
         end
      end
      // Outputs follow the next-state values so that a control or select
      // write shows on the pins at the same edge as the register.
      if (ctrl_next.en) begin
         out_next = {lat_hi_next, lat_lo_next} & select_next[5:0];
      end else begin
         out_next = 6'h00;
      end
      rdata_next = 8'h00;
      if (rd) begin
         if (hit_ctl) begin
            rdata_next = ctrl_rd;
         end else if (hit_sel) begin
            rdata_next = select_reg;
         end else if (hit_lo | hit_hi) begin
            rdata_next = buf_rd;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // State registers.

   always_ff @(posedge clk) begin
      if (reset) begin
         ctrl_reg   <= ctrl_rst[7:4];
         select_reg <= `RTOU_RST_SELECT;
         buf_lo_reg <= `RTOU_RST_BUFFER;
         buf_hi_reg <= `RTOU_RST_BUFFER;
      end else begin
         ctrl_reg   <= ctrl_next;
         select_reg <= select_next;
         buf_lo_reg <= buf_lo_next;
         buf_hi_reg <= buf_hi_next;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         lat_lo_reg              <= 4'h0;
         lat_hi_reg              <= 2'h0;
         realtime_output_signals <= 6'h00;
         rdata                   <= 8'h00;
      end else begin
         lat_lo_reg              <= lat_lo_next;
         lat_hi_reg              <= lat_hi_next;
         realtime_output_signals <= out_next;
         rdata                   <= rdata_next;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Checks.

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   a_disabled_out_zero: assert property (
      !ctrl_reg.en |-> realtime_output_signals == 6'h00)
      else $error("Outputs active while disabled.");

   a_port_bits_zero: assert property (
      ctrl_reg.en |-> (realtime_output_signals & ~select_reg[5:0]) == 6'h00)
      else $error("Port-mode bit drives one.");

   a_follow_latch: assert property (
      ctrl_reg.en |->
      realtime_output_signals == ({lat_hi_reg, lat_lo_reg} & select_reg[5:0]))
      else $error("Output does not follow latch.");

   a_split_write_lo: assert property (
      (wr_lo && !ctrl_reg.wide) |=> $stable(buf_hi_reg))
      else $error("Split write changed high buffer.");

   a_wide_write: assert property (
      (wr_buf && ctrl_reg.wide) |=>
      {buf_hi_reg, buf_lo_reg} == $past(wdata))
      else $error("Combined write did not load both nibbles.");

   a_buffer_read: assert property (
      (rd && (hit_lo || hit_hi)) |=> rdata == $past(buf_rd))
      else $error("Buffer read data wrong.");

   a_ctrl_low_zero: assert property (
      (rd && hit_ctl) |=> rdata == {$past(ctrl_reg), 4'h0})
      else $error("Control low bits not zero.");

   a_direct_load: assert property (
      (!ctrl_reg.en && wr_lo && !ctrl_reg.wide) |=>
      lat_lo_reg == $past(wdata[3:0]))
      else $error("Disabled write did not reach latch.");

   a_no_direct_load: assert property (
      (ctrl_reg.en && wr_buf && !trig_lo && !trig_hi) |=>
      $stable(lat_lo_reg) && $stable(lat_hi_reg))
      else $error("Enabled write changed latch.");

   a_trigger_load: assert property (
      (ctrl_reg.en && trig_lo) |=> lat_lo_reg == $past(buf_lo_reg))
      else $error("Trigger did not load low latch.");

   a_edge_pick: assert property (
      (ctrl_reg.en && ctrl_reg.wide && ctrl_reg.src && !ctrl_reg.edge_rise
       && e1.rise) |=> $stable(lat_lo_reg) && $stable(lat_hi_reg))
      else $error("Wrong edge of first timer used.");

   a_split_source: assert property (
      (ctrl_reg.en && !ctrl_reg.wide && !ctrl_reg.src && t3 && !t2) |=>
      $stable(lat_lo_reg) && lat_hi_reg == $past(buf_hi_reg[1:0]))
      else $error("Split trigger routed wrong.");

   // The trigger checks below other than a_trigger_hi_load pin down one
   // source each, so a wrong entry in the source table shows as a latch
   // that moved or stood.
   a_trigger_hi_load: assert property (
      (ctrl_reg.en && trig_hi) |=> lat_hi_reg == $past(buf_hi_reg[1:0]))
      else $error("Trigger did not load high latch.");

   a_comb_second: assert property (
      (ctrl_reg.en && ctrl_reg.wide && !ctrl_reg.src && t2) |=>
      lat_lo_reg == $past(buf_lo_reg) &&
      lat_hi_reg == $past(buf_hi_reg[1:0]))
      else $error("Combined second-timer trigger missed.");

   a_comb_first: assert property (
      (ctrl_reg.en && ctrl_reg.wide && ctrl_reg.src && ctrl_reg.edge_rise
       && e1.rise) |=>
      lat_lo_reg == $past(buf_lo_reg) &&
      lat_hi_reg == $past(buf_hi_reg[1:0]))
      else $error("Combined first-timer rising trigger missed.");

   a_edge_fall: assert property (
      (ctrl_reg.en && ctrl_reg.wide && ctrl_reg.src && !ctrl_reg.edge_rise
       && e1.fall) |=>
      lat_lo_reg == $past(buf_lo_reg) &&
      lat_hi_reg == $past(buf_hi_reg[1:0]))
      else $error("Falling edge of first timer not used.");

   a_split_hi_src: assert property (
      (ctrl_reg.en && !ctrl_reg.wide && ctrl_reg.src && t2 && !t1_sel) |=>
      $stable(lat_lo_reg) && lat_hi_reg == $past(buf_hi_reg[1:0]))
      else $error("Split high nibble missed second timer.");

   a_split_lo_second: assert property (
      (ctrl_reg.en && !ctrl_reg.wide && !ctrl_reg.src && t2 && !t3) |=>
      lat_lo_reg == $past(buf_lo_reg) && $stable(lat_hi_reg))
      else $error("Split low nibble missed second timer.");

   a_split_lo_first: assert property (
      (ctrl_reg.en && !ctrl_reg.wide && ctrl_reg.src && t1_sel && !t2) |=>
      lat_lo_reg == $past(buf_lo_reg) && $stable(lat_hi_reg))
      else $error("Split low nibble missed first timer.");

   // A trigger while disabled must leave the latches alone; only a
   // buffer write may move them then.
   a_disabled_hold: assert property (
      (!ctrl_reg.en && !wr_buf) |=>
      $stable(lat_lo_reg) && $stable(lat_hi_reg))
      else $error("Latch moved while disabled without a write.");

   a_direct_hi_load: assert property (
      (!ctrl_reg.en && wr_hi && !ctrl_reg.wide) |=>
      lat_hi_reg == $past(wdata[5:4]))
      else $error("Disabled write did not reach high latch.");

   a_split_write_hi: assert property (
      (wr_hi && !ctrl_reg.wide) |=> $stable(buf_lo_reg))
      else $error("Split write changed low buffer.");

   a_select_write: assert property (
      (wr && hit_sel) |=> select_reg == $past(wdata))
      else $error("Select register write lost.");

   a_select_read: assert property (
      (rd && hit_sel) |=> rdata == $past(select_reg))
      else $error("Select register read wrong.");

   a_ctrl_write: assert property (
      (wr && hit_ctl) |=> ctrl_reg == $past(wdata[7:4]))
      else $error("Control write lost.");

   // Checked on the first edge after reset is released.
   a_reset_values: assert property (
      $past(reset) |-> ctrl_reg == ctrl_rst[7:4] &&
      select_reg == `RTOU_RST_SELECT && realtime_output_signals == 6'h00)
      else $error("Register not at reset value.");

endmodule

// File: bench/rtou_timers.sv
// Timer trigger sources that face the real-time output unit.
`timescale 1ns/10ps

module rtou_timers (
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic [2:0] fire,
   output logic            first_timer_match_pulse,
   output logic            second_timer_interrupt,
   output logic            third_timer_interrupt
);
   // A request gives a pulse of one count clock, so a rising and a falling
   // edge follow one cycle apart, which is what separates the edge modes.
   always_ff @(posedge clk) begin
      if (reset) begin
         first_timer_match_pulse <= 1'b0;
         second_timer_interrupt  <= 1'b0;
         third_timer_interrupt   <= 1'b0;
      end else begin
         first_timer_match_pulse <= fire[0];
         second_timer_interrupt  <= fire[1];
         third_timer_interrupt   <= fire[2];
      end
   end
endmodule

// File: bench/rtou_top_test.sv
// Self-checking bench for the real-time output unit.
`timescale 1ns/10ps
`include "rtou_cfg.svh"

module rtou_top_test;
   logic                    clk;
   logic                    reset;
   logic [`RTOU_ADDR_W-1:0] addr;
   logic [7:0]              wdata;
   logic                    wr;
   logic                    rd;
   logic [7:0]              rdata;
   logic [2:0]              fire;
   logic                    t_first;
   logic                    t_second;
   logic                    t_third;
   logic [5:0]              outs;
   int                      failures;
   int                      n_checks;
   int                      cycles = 0;
   logic [31:0]             seed;
   logic [7:0]              m_ctl;
   logic [7:0]              m_sel;
   logic [3:0]              m_hi;
   logic [3:0]              m_lo;
   logic [3:0]              m_lh;
   logic [3:0]              m_ll;

   rtou_top i_rtou_top (
      .clk                     (clk),
      .reset                   (reset),
      .addr                    (addr),
      .wdata                   (wdata),
      .wr                      (wr),
      .rd                      (rd),
      .rdata                   (rdata),
      .first_timer_match_pulse (t_first),
      .second_timer_interrupt  (t_second),
      .third_timer_interrupt   (t_third),
      .realtime_output_signals (outs)
   );

   rtou_timers i_rtou_timers (
      .clk                     (clk),
      .reset                   (reset),
      .fire                    (fire),
      .first_timer_match_pulse (t_first),
      .second_timer_interrupt  (t_second),
      .third_timer_interrupt   (t_third)
   );

   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   function automatic logic [7:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction

   task automatic end_of_test();
      if (failures == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_out();
      chk_rd({2'b00, outs},
             m_ctl[7] ? {2'b00, m_lh[1:0] & m_sel[5:4], m_ll & m_sel[3:0]}
                      : 8'h00);
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic wr_reg(input logic [`RTOU_ADDR_W-1:0] a,
                         input logic [7:0]              d);
      logic hw;
      logic lw;
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      hw = a == `RTOU_OFS_BUF_HI || (m_ctl[5] && a == `RTOU_OFS_BUF_LO);
      lw = a == `RTOU_OFS_BUF_LO || (m_ctl[5] && a == `RTOU_OFS_BUF_HI);
      if (hw) m_hi = d[7:4];
      if (lw) m_lo = d[3:0];
      if (hw && !m_ctl[7]) m_lh = d[7:4];
      if (lw && !m_ctl[7]) m_ll = d[3:0];
      if (a == `RTOU_OFS_CONTROL) m_ctl = d & 8'hf0;
      if (a == `RTOU_OFS_SELECT) m_sel = d;
      @(negedge clk);
      chk_out();
   endtask

   task automatic rd_reg(input logic [`RTOU_ADDR_W-1:0] a,
                         input logic [7:0]              exp);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      chk_rd(rdata, exp);
      @(negedge clk);
      chk_rd(rdata, 8'h00);
   endtask

   task automatic rd_all();
      rd_reg(`RTOU_OFS_CONTROL, m_ctl);
      rd_reg(`RTOU_OFS_SELECT, m_sel);
      rd_reg(`RTOU_OFS_BUF_LO, {m_hi, m_lo});
      rd_reg(`RTOU_OFS_BUF_HI, {m_hi, m_lo});
      rd_reg(28'hffff6e2, 8'h00);
   endtask

   // Checked one cycle after the rising edge is seen and again one cycle
   // after the falling edge, so either edge mode shows a distinct timing.
   task automatic trig(input int i);
      logic h;
      logic l;
      h = m_ctl[5] ? (m_ctl[4] ? i == 0 : i == 1)
                   : (m_ctl[4] ? i == 1 : i == 2);
      l = m_ctl[5] ? h : (m_ctl[4] ? i == 0 : i == 1);
      @(posedge clk);
      fire[i] <= 1'b1;
      @(posedge clk);
      fire[i] <= 1'b0;
      @(posedge clk);
      for (int j = 0; j < 2; j++) begin
         if (m_ctl[7] && (j == 1 || i != 0 || m_ctl[6])) begin
            if (h) m_lh = m_hi;
            if (l) m_ll = m_lo;
         end
         @(negedge clk);
         chk_out();
         @(posedge clk);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         failures++;
         end_of_test();
      end
   end

   initial begin
      reset = 1'b1;
      addr  = '0;
      wdata = 8'h00;
      wr    = 1'b0;
      rd    = 1'b0;
      fire  = 3'b000;
      seed  = 32'h45e6;
      failures = 0;
      n_checks = 0;
      m_ctl = 8'h00;
      m_sel = 8'h00;
      m_hi  = 4'h0;
      m_lo  = 4'h0;
      m_lh  = 4'h0;
      m_ll  = 4'h0;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      rd_all();
      for (int m = 0; m < 8; m++) begin
         wr_reg(`RTOU_OFS_CONTROL, 8'h00);
         wr_reg(`RTOU_OFS_CONTROL, {1'b0, m[2:0], 4'hf});
         wr_reg(`RTOU_OFS_SELECT, rnd());
         wr_reg(`RTOU_OFS_BUF_LO, rnd());
         wr_reg(`RTOU_OFS_BUF_HI, rnd());
         trig(m % 3);
         wr_reg(`RTOU_OFS_CONTROL, {1'b1, m[2:0], 4'h0});
         rd_all();
         for (int k = 0; k < 6; k++) begin
            wr_reg(k[0] ? `RTOU_OFS_BUF_HI : `RTOU_OFS_BUF_LO, rnd());
            trig(k % 3);
         end
         wr_reg(28'hffff6e2, rnd());
         rd_all();
      end
      // A second reset in mid-run must bring every register back.
      @(posedge clk);
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      m_ctl = 8'h00;
      m_sel = 8'h00;
      m_hi  = 4'h0;
      m_lo  = 4'h0;
      m_lh  = 4'h0;
      m_ll  = 4'h0;
      rd_all();
      wr_reg(`RTOU_OFS_CONTROL, 8'h80);
      end_of_test();
   end
endmodule
